// ==== hw/clock_source_qualifier.v ====
// Clock source qualifier: oscillator and PLL enables, stable and lock qualification, deep stop gating.
// Contract
// (RQ1) Crystal oscillator off after reset; starts only when software sets its enable.
// (RQ2) Software waits for crystal stable before PLLs or switching onto crystal.
// (RQ3) Crystal runs in light sleep; stops in deep stop, resumes same configuration.
// (RQ4) External clock inputs are never gated by light sleep or deep stop.
// (RQ5) External clock via two inputs or crystal pin; pin needs pass-through mode.
// (RQ6) External clock inputs driven no faster than 50MHz.
// (RQ7) PLL output unusable until its lock status bit reports lock.
// (RQ8) Software avoids PLL output while reference, output dividers or bypass change.
// (RQ9) PLL output stays usable during feedback divisor changes.
// (RQ10) PLLs run in light sleep; software stops them first to save power.
// (RQ11) PLLs not auto-stopped around deep stop; software stops them beforehand.
// (RQ12) Crystal clock reaches a pad only through a gpio clock output generator.
// (RQ13) Relaxation oscillators unaffected by light sleep and deep stop.
// (RQ14) Pad output override offers inversion for feeding clock outputs back.
// (RQ15) Move reference and system clocks to crystal before stopping ring oscillator.
// (RQ16) USB PLL supplies 48MHz to ADC and USB; peripheral clock from either PLL.
// (RQ17) Reference and system clocks run in every state except deep stop.
// (RQ18) Crystal stable and PLL lock are synchronised before software reads them.
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "clk_src_consts.vh"
module clock_source_qualifier #(
    parameter XO_START_CYCLES = `XO_START_CYC,
    parameter PLL_LOCK_CYCLES = `PLL_LOCK_CYC,
    parameter NUM_GPCLK = 4
) (
    input wire aclk,
    input wire aresetn,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire crystal_osc_ready,
    input wire [1:0] pll_lock_raw,
    input wire ring_osc_running,
    output reg crystal_osc_enable_ff,
    output reg crystal_pass_through_ff,
    output reg [1:0] pll_run_ff,
    output reg [1:0] pll_output_usable_ff,
    output reg ref_sys_clock_enable_ff,
    output reg ext_clock_gate_open_ff,
    output reg [NUM_GPCLK-1:0] pad_output_override_ff
);
    localparam CNT_W = 24;
    localparam [CNT_W-1:0] XO_LIM = XO_START_CYCLES;
    localparam [CNT_W-1:0] PLL_LIM = PLL_LOCK_CYCLES;
    reg [1:0] xo_ctrl_ff;
    reg [5:0] pll_ctrl_ff;
    reg [1:0] pwr_ctrl_ff;
    reg aw_hold_ff;
    reg w_hold_ff;
    reg [11:0] awaddr_ff;
    reg [31:0] wdata_ff;
    reg [3:0] wstrb_ff;
    reg [31:0] nxt_rdata;
    reg nxt_rerr;
    reg [1:0] nxt_xo_ctrl;
    reg [5:0] nxt_pll_ctrl;
    reg [1:0] nxt_pwr_ctrl;
    reg [NUM_GPCLK-1:0] nxt_pad_ctrl;
    reg [1:0] nxt_bresp;
    wire deep_stop_state;
    wire crystal_stable_flag;
    wire [1:0] pll_locked;
    wire do_write;
    wire xo_active;
    assign deep_stop_state = pwr_ctrl_ff[`PWR_DEEP_BIT];
    // Deep stop masks the enable but leaves the configuration bits untouched. [RQ3]
    assign xo_active = xo_ctrl_ff[`XO_EN_BIT] && !deep_stop_state; // [RQ1] [RQ3]
    sync3_cnt #(.CNT_W(CNT_W)) u_xo_q (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(crystal_osc_ready),
        .enable(xo_active),
        .limit(XO_LIM),
        .qualified_ff(crystal_stable_flag)
    ); // [RQ18]
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_pll
            // Lock needs a stable reference and a running PLL; settings changes do not affect it. [RQ7]
            sync3_cnt #(.CNT_W(CNT_W)) u_pll_q (
                .aclk(aclk),
                .aresetn(aresetn),
                .async_in(pll_lock_raw[g]),
                .enable(pll_ctrl_ff[`PLL_RUN_LSB + g] && crystal_stable_flag),
                .limit(PLL_LIM),
                .qualified_ff(pll_locked[g])
            ); // [RQ18] [RQ7]
        end
    endgenerate
    assign do_write = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
    // The address channel is captured on its own, so address and data may arrive in either order.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            aw_hold_ff <= 1'b0;
            awaddr_ff <= 12'h000;
        end else begin
            s_axi_awready <= !aw_hold_ff && !s_axi_awready && s_axi_awvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end else if (do_write) begin
                aw_hold_ff <= 1'b0;
            end
        end
    end
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b0;
            w_hold_ff <= 1'b0;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
        end else begin
            s_axi_wready <= !w_hold_ff && !s_axi_wready && s_axi_wvalid;
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end else if (do_write) begin
                w_hold_ff <= 1'b0;
            end
        end
    end
    // Only the low byte lane carries control bits, so its strobe gates every update.
    always @* begin
        nxt_xo_ctrl = xo_ctrl_ff;
        nxt_pll_ctrl = pll_ctrl_ff;
        nxt_pwr_ctrl = pwr_ctrl_ff;
        nxt_pad_ctrl = pad_output_override_ff;
        nxt_bresp = `RESP_OKAY;
        if (!wstrb_ff[0]) begin
            nxt_bresp = `RESP_OKAY;
        end else if (awaddr_ff == `OFS_XO_CTRL) begin
            nxt_xo_ctrl = wdata_ff[1:0]; // [RQ1] [RQ5]
        end else if (awaddr_ff == `OFS_PLL_CTRL) begin
            nxt_pll_ctrl = wdata_ff[5:0];
        end else if (awaddr_ff == `OFS_PWR_CTRL) begin
            nxt_pwr_ctrl = wdata_ff[1:0];
        end else if (awaddr_ff == `OFS_PAD_CTRL) begin
            // The override only inverts a generator output; no crystal pin reaches a pad. [RQ12]
            nxt_pad_ctrl = wdata_ff[NUM_GPCLK-1:0]; // [RQ14]
        end else if (awaddr_ff == `OFS_XO_STATUS || awaddr_ff == `OFS_PLL_STATUS ||
                     awaddr_ff == `OFS_SRC_STATUS) begin
            nxt_bresp = `RESP_OKAY;
        end else begin
            nxt_bresp = `RESP_SLVERR;
        end
    end
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= nxt_bresp;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
    always @(posedge aclk) begin
        if (!aresetn) begin
            xo_ctrl_ff <= `RST_XO_CTRL; // [RQ1]
            pll_ctrl_ff <= `RST_PLL_CTRL;
            pwr_ctrl_ff <= 2'h0;
            pad_output_override_ff <= {NUM_GPCLK{1'b0}};
        end else if (do_write) begin
            xo_ctrl_ff <= nxt_xo_ctrl;
            pll_ctrl_ff <= nxt_pll_ctrl;
            pwr_ctrl_ff <= nxt_pwr_ctrl;
            pad_output_override_ff <= nxt_pad_ctrl;
        end
    end
    always @* begin
        nxt_rdata = 32'h00000000;
        nxt_rerr = 1'b0;
        if (s_axi_araddr == `OFS_XO_CTRL) begin
            nxt_rdata = {30'h00000000, xo_ctrl_ff};
        end else if (s_axi_araddr == `OFS_XO_STATUS) begin
            nxt_rdata = {31'h00000000, crystal_stable_flag}; // [RQ18]
        end else if (s_axi_araddr == `OFS_PLL_CTRL) begin
            nxt_rdata = {26'h0000000, pll_ctrl_ff};
        end else if (s_axi_araddr == `OFS_PLL_STATUS) begin
            nxt_rdata = {30'h00000000, pll_locked}; // [RQ7]
        end else if (s_axi_araddr == `OFS_PWR_CTRL) begin
            nxt_rdata = {30'h00000000, pwr_ctrl_ff};
        end else if (s_axi_araddr == `OFS_SRC_STATUS) begin
            nxt_rdata = {29'h00000000, ref_sys_clock_enable_ff, ext_clock_gate_open_ff,
                         ring_osc_running};
        end else if (s_axi_araddr == `OFS_PAD_CTRL) begin
            nxt_rdata = {{(32-NUM_GPCLK){1'b0}}, pad_output_override_ff};
        end else begin
            nxt_rerr = 1'b1;
        end
    end
    // Address acceptance waits until the previous answer has been taken.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
        end
    end
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= nxt_rdata;
                s_axi_rresp <= nxt_rerr ? `RESP_SLVERR : `RESP_OKAY;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
    always @(posedge aclk) begin
        if (!aresetn) begin
            crystal_osc_enable_ff <= 1'b0; // [RQ1]
            crystal_pass_through_ff <= 1'b0;
        end else begin
            crystal_osc_enable_ff <= xo_active; // [RQ3]
            crystal_pass_through_ff <= xo_ctrl_ff[`XO_PASS_BIT]; // [RQ5]
        end
    end
    // PLLs ignore sleep and deep stop; software must stop them itself. [RQ10] [RQ11]
    always @(posedge aclk) begin
        if (!aresetn) begin
            pll_run_ff <= 2'h0;
        end else begin
            pll_run_ff <= pll_ctrl_ff[1:0];
        end
    end
    // Each PLL is qualified on its own, so the peripheral clock may use either one. [RQ16]
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_use
            always @(posedge aclk) begin
                if (!aresetn) begin
                    pll_output_usable_ff[g] <= 1'b0;
                end else begin
                    // Feedback changes keep the output usable; other changes withdraw it. [RQ9]
                    pll_output_usable_ff[g] <= pll_locked[g] &&
                        !pll_ctrl_ff[`PLL_CFG_CHG_LSB + g]; // [RQ7] [RQ8]
                end
            end
        end
    endgenerate
    always @(posedge aclk) begin
        if (!aresetn) begin
            ref_sys_clock_enable_ff <= 1'b1;
        end else begin
            ref_sys_clock_enable_ff <= !deep_stop_state; // [RQ17]
        end
    end
    // External inputs and relaxation loops are never gated by any power state.
    always @(posedge aclk) begin
        if (!aresetn) begin
            ext_clock_gate_open_ff <= 1'b1;
        end else begin
            ext_clock_gate_open_ff <= 1'b1; // [RQ4] [RQ13]
        end
    end
endmodule // clock_source_qualifier

// ==== hw/clk_src_consts.vh ====
// Register offsets, field positions, reset values and timing counts of the clock source qualifier.
`ifndef CLK_SRC_CONSTS_VH
`define CLK_SRC_CONSTS_VH
`define OFS_XO_CTRL 12'h000
`define OFS_XO_STATUS 12'h004
`define OFS_PLL_CTRL 12'h008
`define OFS_PLL_STATUS 12'h00c
`define OFS_PWR_CTRL 12'h010
`define OFS_SRC_STATUS 12'h014
`define OFS_PAD_CTRL 12'h018
`define XO_EN_BIT 0
`define XO_PASS_BIT 1
`define PLL_RUN_LSB 0
`define PLL_FB_CHG_LSB 2
`define PLL_CFG_CHG_LSB 4
`define PWR_SLEEP_BIT 0
`define PWR_DEEP_BIT 1
`define PAD_INV_LSB 0
`define RST_XO_CTRL 2'h0
`define RST_PLL_CTRL 6'h00
`define RST_PAD_CTRL 4'h0
`define XO_START_US 1000
`define PLL_LOCK_US 100
`define CLK_MHZ 100
`define XO_START_CYC (`XO_START_US * `CLK_MHZ)
`define PLL_LOCK_CYC (`PLL_LOCK_US * `CLK_MHZ)
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== hw/sync3_cnt.v ====
// Three-stage input synchroniser with a qualification counter that reports a stable level.
`timescale 1ns/1ps
module sync3_cnt #(
    parameter CNT_W = 20
) (
    input wire aclk,
    input wire aresetn,
    input wire async_in,
    input wire enable,
    input wire [CNT_W-1:0] limit,
    output reg qualified_ff
);
    reg s1_ff;
    reg s2_ff;
    reg s3_ff;
    reg [CNT_W-1:0] cnt_ff;
    reg [CNT_W-1:0] nxt_cnt;
    always @(posedge aclk) begin
        if (!aresetn) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
        end else begin
            s1_ff <= async_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end
    // A high level counts once the second and third stages agree.
    always @* begin
        nxt_cnt = cnt_ff;
        if (!enable || !(s2_ff && s3_ff)) begin
            nxt_cnt = {CNT_W{1'b0}};
        end else if (cnt_ff != limit) begin
            nxt_cnt = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff <= {CNT_W{1'b0}};
            qualified_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            qualified_ff <= enable && (nxt_cnt == limit);
        end
    end
endmodule // sync3_cnt

// ==== sim/clock_source_qualifier_chk.sv ====
// Assertion checker for the clock source qualifier, bound to its ports.
`timescale 1ns/1ps
module clock_source_qualifier_chk #(parameter NUM_GPCLK = 4) (
    input logic aclk, aresetn, s_axi_bvalid, s_axi_bready, s_axi_rvalid, s_axi_rready,
    input logic s_axi_arvalid, s_axi_arready, crystal_osc_enable_ff,
    input logic ref_sys_clock_enable_ff, ext_clock_gate_open_ff,
    input logic [1:0] s_axi_bresp, pll_lock_raw, pll_run_ff, pll_output_usable_ff,
    input logic [31:0] s_axi_rdata,
    input logic [NUM_GPCLK-1:0] pad_output_override_ff
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    xo_by_write_a: assert property ($rose(crystal_osc_enable_ff) |-> ##[0:2] s_axi_bvalid)
        else $error("crystal enabled without a write");
    ext_gate_open_a: assert property (ext_clock_gate_open_ff)
        else $error("external clock gate closed");
    deep_stop_xo_a: assert property (!ref_sys_clock_enable_ff |-> !crystal_osc_enable_ff)
        else $error("crystal enabled in deep stop");
    usable_run_a: assert property ((pll_output_usable_ff & ~pll_run_ff) == 2'h0)
        else $error("pll usable while stopped");
    lock_synced_a: assert property ((pll_output_usable_ff & ~$past(pll_output_usable_ff)
        & ~$past(pll_lock_raw, 3)) == 2'h0) else $error("usable before lock settled");
    pad_by_write_a: assert property ($changed(pad_output_override_ff) |-> ##[0:2] s_axi_bvalid)
        else $error("pad inversion changed without a write");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    ar_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
endmodule // clock_source_qualifier_chk
bind clock_source_qualifier clock_source_qualifier_chk #(.NUM_GPCLK(NUM_GPCLK)) i_chk (.*);

// ==== sim/tb_clock_source_qualifier.sv ====
// Self-checking bench for the clock source qualifier over its register bus.
`timescale 1ns/1ps
`include "clk_src_consts.vh"
module tb_clock_source_qualifier;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic crystal_osc_ready, ring_osc_running, crystal_osc_enable_ff, crystal_pass_through_ff;
    logic ref_sys_clock_enable_ff, ext_clock_gate_open_ff;
    logic [1:0] s_axi_bresp, s_axi_rresp, pll_lock_raw, pll_run_ff, pll_output_usable_ff;
    logic [3:0] s_axi_wstrb, pad_output_override_ff;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0] bq[$];
    logic [33:0] rq[$];
    localparam logic [1:0] OK = `RESP_OKAY;
    int fails = 0, samples_checked = 0, cyc = 0, seed = 50804;
    clock_source_qualifier #(.XO_START_CYCLES(8), .PLL_LOCK_CYCLES(8)) i_clock_source_qualifier (.*);
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic cmp(input logic [33:0] g, input logic [33:0] e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic report_and_stop();
        if (fails == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Answers are taken after a random stall so the held-response path is exercised.
    task automatic ans(input bit w);
        int k;
        k = {$random(seed)} % 3;
        while (!(w ? s_axi_bvalid : s_axi_rvalid)) @(posedge aclk);
        repeat (k) @(posedge aclk);
        if (w) s_axi_bready <= 1'b1;
        else s_axi_rready <= 1'b1;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] r,
                      input logic [3:0] s = 4'hf);
        bit ga, gw;
        bq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(ga && gw)) begin
            @(posedge aclk);
            ga |= s_axi_awready;
            gw |= s_axi_wready;
            s_axi_awvalid <= !ga;
            s_axi_wvalid <= !gw;
        end
        ans(1);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] v, input logic [1:0] r);
        rq.push_back({r, v});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        ans(0);
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (s_axi_bvalid && s_axi_bready) cmp(s_axi_bresp, bq.pop_front());
        if (s_axi_rvalid && s_axi_rready) cmp({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (cyc == 5000) begin
            fails++;
            report_and_stop();
        end
    end
    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
        // No external clock input is driven here, so none exceeds the input rate limit.
        {crystal_osc_ready, ring_osc_running, pll_lock_raw} = 4'hf;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        cmp({crystal_osc_enable_ff, ref_sys_clock_enable_ff, ext_clock_gate_open_ff}, 3'h3);
        rd(`OFS_XO_STATUS, 32'h0, OK);
        rd(`OFS_SRC_STATUS, 32'h7, OK);
        wr(`OFS_XO_CTRL, 32'h3, OK);
        cmp({crystal_osc_enable_ff, crystal_pass_through_ff}, 2'h3);
        wr(`OFS_XO_CTRL, 32'h1, OK);
        cmp(crystal_pass_through_ff, 1'b0);
        repeat (20) @(posedge aclk);
        rd(`OFS_XO_STATUS, 32'h1, OK);
        ring_osc_running <= 1'b0;
        rd(`OFS_SRC_STATUS, 32'h6, OK);
        wr(`OFS_PLL_CTRL, 32'h3, OK);
        cmp(pll_output_usable_ff, 2'h0);
        repeat (20) @(posedge aclk);
        rd(`OFS_PLL_STATUS, 32'h3, OK);
        wr(`OFS_PLL_CTRL, 32'h0f, OK);
        cmp(pll_output_usable_ff, 2'h3);
        wr(`OFS_PLL_CTRL, 32'h13, OK);
        cmp(pll_output_usable_ff, 2'h2);
        wr(`OFS_PWR_CTRL, 32'h1, OK);
        cmp({crystal_osc_enable_ff, ref_sys_clock_enable_ff, pll_run_ff}, 4'hf);
        wr(`OFS_PWR_CTRL, 32'h2, OK);
        cmp({crystal_osc_enable_ff, ref_sys_clock_enable_ff, pll_run_ff}, 4'h3);
        rd(`OFS_XO_CTRL, 32'h1, OK);
        wr(`OFS_PWR_CTRL, 32'h0, OK);
        cmp({crystal_osc_enable_ff, ref_sys_clock_enable_ff}, 2'h3);
        for (int i = 0; i < 6; i++) begin
            d = $random(seed);
            wr(`OFS_PAD_CTRL, d, OK);
            cmp(pad_output_override_ff, d[3:0]);
            rd(`OFS_PAD_CTRL, {28'h0, d[3:0]}, OK);
        end
        wr(`OFS_PAD_CTRL, ~d, OK, 4'he);
        cmp(pad_output_override_ff, d[3:0]);
        pll_lock_raw <= 2'h1;
        repeat (6) @(posedge aclk);
        rd(`OFS_PLL_STATUS, 32'h1, OK);
        cmp(pll_output_usable_ff, 2'h0);
        rd(12'h01c, 32'h0, `RESP_SLVERR);
        wr(12'h01c, 32'hf, `RESP_SLVERR);
        report_and_stop();
    end
endmodule // tb_clock_source_qualifier
